// >>> common/ocd_defs.svh
// Opcode map constants for the instruction decoder.
// Assumes inclusion by bare name from the package and design.
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
`define OCD_HI_BTB       4'h0
`define OCD_HI_BSC       4'h1
`define OCD_HI_REL       4'h2
`define OCD_HI_RMW_DIR   4'h3
`define OCD_HI_RMW_ACC   4'h4
`define OCD_HI_RMW_IDX   4'h5
`define OCD_HI_RMW_IX1   4'h6
`define OCD_HI_RMW_IX    4'h7
`define OCD_HI_CTL8      4'h8
`define OCD_HI_CTL9      4'h9
`define OCD_HI_RM_IMM    4'ha
`define OCD_HI_RM_DIR    4'hb
`define OCD_HI_RM_EXT    4'hc
`define OCD_HI_RM_IX2    4'hd
`define OCD_HI_RM_IX1    4'he
`define OCD_HI_RM_IX     4'hf
`define OCD_LO_RTI       4'h0
`define OCD_LO_RTS       4'h1
`define OCD_LO_SWT       4'h3
`define OCD_LO_STOP      4'he
`define OCD_LO_WAIT      4'hf
`define OCD_LO_STA       4'h7
`define OCD_LO_JMP       4'hc
`define OCD_LO_JSR       4'hd
`define OCD_LO_STX       4'hf
`define OCD_HALF_BIT     3
`define OCD_SIGN_BIT     7
`define OCD_CC_H         4
`define OCD_CC_I         3
`define OCD_CC_N         2
`define OCD_CC_Z         1
`define OCD_CC_C         0
`define OCD_CC_RESET     5'h08
`endif

// >>> common/ocd_pkg.sv
// Types shared by the instruction decoder and its users.
// Assumes ocd_defs.svh is on the include path.
`include "ocd_defs.svh"
package ocd_pkg;
    typedef enum logic [3:0] {
        OCD_MODE_INHERENT, OCD_MODE_IMMEDIATE, OCD_MODE_DIRECT,
        OCD_MODE_EXTENDED, OCD_MODE_RELATIVE, OCD_MODE_IX,
        OCD_MODE_IX1, OCD_MODE_IX2, OCD_MODE_BSC, OCD_MODE_BTB,
        OCD_MODE_NONE
    } ocd_mode_t;
    typedef enum logic [5:0] {
        OCD_OP_ILLEGAL, OCD_OP_BRANCH_IF_BIT_SET, OCD_OP_BRANCH_IF_BIT_CLEAR, OCD_OP_SET_MEMORY_BIT,
        OCD_OP_CLEAR_MEMORY_BIT, OCD_OP_BRANCH, OCD_OP_NEG, OCD_OP_COM,
        OCD_OP_LSR, OCD_OP_ROR, OCD_OP_ASR, OCD_OP_LSL, OCD_OP_ROL,
        OCD_OP_DEC, OCD_OP_INC, OCD_OP_TST, OCD_OP_CLR,
        OCD_OP_RTI, OCD_OP_RTS, OCD_OP_SWT, OCD_OP_STOP,
        OCD_OP_WAIT, OCD_OP_TAX, OCD_OP_CLC, OCD_OP_SEC,
        OCD_OP_CLI, OCD_OP_SEI, OCD_OP_RSP, OCD_OP_NOP, OCD_OP_TXA,
        OCD_OP_SUB, OCD_OP_CMP, OCD_OP_SBC, OCD_OP_CPX, OCD_OP_AND,
        OCD_OP_BIT, OCD_OP_LDA, OCD_OP_STA, OCD_OP_EOR, OCD_OP_ADC,
        OCD_OP_ORA, OCD_OP_ADD, OCD_OP_JMP, OCD_OP_JSR, OCD_OP_LDX,
        OCD_OP_STX, OCD_OP_BSR
    } ocd_op_t;
    typedef enum logic [3:0] {
        OCD_BR_ALWAYS, OCD_BR_NEVER, OCD_BR_HI, OCD_BR_LS,
        OCD_BR_CC, OCD_BR_CS, OCD_BR_NE, OCD_BR_EQ, OCD_BR_HCC,
        OCD_BR_HCS, OCD_BR_PL, OCD_BR_MI, OCD_BR_MC, OCD_BR_MS,
        OCD_BR_IL, OCD_BR_IH
    } ocd_cond_t;
    typedef struct packed {
        ocd_op_t   op;
        ocd_mode_t mode;
        ocd_cond_t cond;
        logic [2:0] bit_num;
        logic [1:0] length;
        logic [1:0] offset_bytes;
        logic       illegal;
    } ocd_decode_t;
    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half_carry;
        logic [4:0] stacked_cc;
    } ocd_alu_t;
endpackage

// >>> logic/ocd_decoder.sv
// Opcode decoder with condition code register update.
// Assumes fetch presents one opcode per cycle with opcode_valid, and the
// datapath returns each result with result_valid and the decoded op.
// Function
// - Row 0 bit branch, row 1 bit set/clear
// - Row 2 relative branches by condition
// - Rows 3-7 read-modify-write operand and operation
// - Row 8: returns, trap, stop, wait
// - Rows A-F register/memory modes and operations
// - No immediate store/jump; AD is branch-subroutine
// - Indexed offsets: two, one or none bytes
// - Half carry from bit 3, adds only
// - Affected flags follow result, others held
// - Interrupt return reloads all five flags
// - Sign to N; mask forced by ops
// - Bit number from opcode bits 3..1
`timescale 1ns/10ps
`default_nettype none
`include "ocd_defs.svh"
module ocd_decoder (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // Opcode from fetch
    input  wire logic                 opcode_valid,
    input  wire logic [7:0]           opcode,
    // Decoded instruction
    output ocd_pkg::ocd_decode_t      decode_q,
    output logic                      decode_valid_q,
    output logic                      illegal_opcode_q,
    // Result from datapath
    input  wire logic                 result_valid,
    input  wire ocd_pkg::ocd_op_t     result_op,
    input  wire ocd_pkg::ocd_alu_t    alu,
    // Condition codes H I N Z C
    output logic [4:0]                cc_q
);
    import ocd_pkg::*;

    logic [3:0]  hi;
    logic [3:0]  lo;
    ocd_decode_t dec_d;
    logic [4:0]  cc_d;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    always_comb begin
        dec_d = '{op: OCD_OP_ILLEGAL, mode: OCD_MODE_NONE,
                  cond: OCD_BR_NEVER, bit_num: opcode[3:1],
                  length: 2'd1, offset_bytes: 2'd0, illegal: 1'b0};
        unique case (hi)
            `OCD_HI_BTB: begin
                dec_d.op = opcode[0] ? OCD_OP_BRANCH_IF_BIT_CLEAR : OCD_OP_BRANCH_IF_BIT_SET;
                dec_d.mode = OCD_MODE_BTB;
                dec_d.length = 2'd3;
            end
            `OCD_HI_BSC: begin
                dec_d.op = opcode[0] ? OCD_OP_CLEAR_MEMORY_BIT : OCD_OP_SET_MEMORY_BIT;
                dec_d.mode = OCD_MODE_BSC;
                dec_d.length = 2'd2;
            end
            `OCD_HI_REL: begin
                dec_d.op = OCD_OP_BRANCH;
                dec_d.cond = ocd_cond_t'(lo);
                dec_d.mode = OCD_MODE_RELATIVE;
                dec_d.length = 2'd2;
            end
            `OCD_HI_RMW_DIR, `OCD_HI_RMW_ACC, `OCD_HI_RMW_IDX,
            `OCD_HI_RMW_IX1, `OCD_HI_RMW_IX: begin
                unique case (lo)
                    4'h0: dec_d.op = OCD_OP_NEG;
                    4'h3: dec_d.op = OCD_OP_COM;
                    4'h4: dec_d.op = OCD_OP_LSR;
                    4'h6: dec_d.op = OCD_OP_ROR;
                    4'h7: dec_d.op = OCD_OP_ASR;
                    4'h8: dec_d.op = OCD_OP_LSL;
                    4'h9: dec_d.op = OCD_OP_ROL;
                    4'ha: dec_d.op = OCD_OP_DEC;
                    4'hc: dec_d.op = OCD_OP_INC;
                    4'hd: dec_d.op = OCD_OP_TST;
                    4'hf: dec_d.op = OCD_OP_CLR;
                    default: dec_d.op = OCD_OP_ILLEGAL;
                endcase
                unique case (hi)
                    `OCD_HI_RMW_DIR: begin
                        dec_d.mode = OCD_MODE_DIRECT;
                        dec_d.length = 2'd2;
                    end
                    `OCD_HI_RMW_IX1: begin
                        dec_d.mode = OCD_MODE_IX1;
                        dec_d.length = 2'd2;
                        dec_d.offset_bytes = 2'd1;
                    end
                    `OCD_HI_RMW_IX: dec_d.mode = OCD_MODE_IX;
                    default: dec_d.mode = OCD_MODE_INHERENT;
                endcase
            end
            `OCD_HI_CTL8: begin
                dec_d.mode = OCD_MODE_INHERENT;
                unique case (lo)
                    `OCD_LO_RTI:  dec_d.op = OCD_OP_RTI;
                    `OCD_LO_RTS:  dec_d.op = OCD_OP_RTS;
                    `OCD_LO_SWT:  dec_d.op = OCD_OP_SWT;
                    `OCD_LO_STOP: dec_d.op = OCD_OP_STOP;
                    `OCD_LO_WAIT: dec_d.op = OCD_OP_WAIT;
                    default:      dec_d.op = OCD_OP_ILLEGAL;
                endcase
            end
            `OCD_HI_CTL9: begin
                dec_d.mode = OCD_MODE_INHERENT;
                unique case (lo)
                    4'h7: dec_d.op = OCD_OP_TAX;
                    4'h8: dec_d.op = OCD_OP_CLC;
                    4'h9: dec_d.op = OCD_OP_SEC;
                    4'ha: dec_d.op = OCD_OP_CLI;
                    4'hb: dec_d.op = OCD_OP_SEI;
                    4'hc: dec_d.op = OCD_OP_RSP;
                    4'hd: dec_d.op = OCD_OP_NOP;
                    4'hf: dec_d.op = OCD_OP_TXA;
                    default: dec_d.op = OCD_OP_ILLEGAL;
                endcase
            end
            default: begin
                dec_d.op = ocd_op_t'(6'(OCD_OP_SUB) + 6'(lo));
                unique case (hi)
                    `OCD_HI_RM_IMM: begin
                        dec_d.mode = OCD_MODE_IMMEDIATE;
                        dec_d.length = 2'd2;
                        if (lo == `OCD_LO_JSR) begin
                            dec_d.op = OCD_OP_BSR;
                            dec_d.mode = OCD_MODE_RELATIVE;
                        end else if (lo == `OCD_LO_STA ||
                                     lo == `OCD_LO_JMP ||
                                     lo == `OCD_LO_STX) begin
                            dec_d.op = OCD_OP_ILLEGAL;
                        end
                    end
                    `OCD_HI_RM_DIR: begin
                        dec_d.mode = OCD_MODE_DIRECT;
                        dec_d.length = 2'd2;
                    end
                    `OCD_HI_RM_EXT: begin
                        dec_d.mode = OCD_MODE_EXTENDED;
                        dec_d.length = 2'd3;
                    end
                    `OCD_HI_RM_IX2: begin
                        dec_d.mode = OCD_MODE_IX2;
                        dec_d.length = 2'd3;
                        dec_d.offset_bytes = 2'd2;
                    end
                    `OCD_HI_RM_IX1: begin
                        dec_d.mode = OCD_MODE_IX1;
                        dec_d.length = 2'd2;
                        dec_d.offset_bytes = 2'd1;
                    end
                    default: dec_d.mode = OCD_MODE_IX;
                endcase
            end
        endcase
        if (dec_d.op == OCD_OP_ILLEGAL) begin
            dec_d.illegal = 1'b1;
            dec_d.mode = OCD_MODE_NONE;
            dec_d.length = 2'd1;
            dec_d.offset_bytes = 2'd0;
        end
    end

    // Decode register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            decode_q <= '{op: OCD_OP_ILLEGAL, mode: OCD_MODE_NONE,
                          cond: OCD_BR_NEVER, bit_num: 3'h0,
                          length: 2'd0, offset_bytes: 2'd0,
                          illegal: 1'b0};
            decode_valid_q <= 1'b0;
            illegal_opcode_q <= 1'b0;
        end else begin
            decode_valid_q <= opcode_valid;
            illegal_opcode_q <= opcode_valid & dec_d.illegal;
            if (opcode_valid) begin
                decode_q <= dec_d;
            end
        end
    end

    // Flag update per instruction class
    always_comb begin
        logic zero;
        logic neg;
        zero = (alu.result == 8'h00);
        neg = alu.result[`OCD_SIGN_BIT];
        cc_d = cc_q;
        if (result_valid) begin
            unique case (result_op)
                OCD_OP_ADD, OCD_OP_ADC: begin
                    cc_d[`OCD_CC_H] = alu.half_carry;
                    cc_d[`OCD_CC_N] = neg;
                    cc_d[`OCD_CC_Z] = zero;
                    cc_d[`OCD_CC_C] = alu.carry;
                end
                OCD_OP_SUB, OCD_OP_CMP, OCD_OP_SBC, OCD_OP_CPX,
                OCD_OP_NEG, OCD_OP_LSR, OCD_OP_ROR, OCD_OP_ASR,
                OCD_OP_LSL, OCD_OP_ROL, OCD_OP_COM: begin
                    cc_d[`OCD_CC_N] = neg;
                    cc_d[`OCD_CC_Z] = zero;
                    cc_d[`OCD_CC_C] = alu.carry;
                end
                OCD_OP_AND, OCD_OP_BIT, OCD_OP_LDA, OCD_OP_STA,
                OCD_OP_EOR, OCD_OP_ORA, OCD_OP_LDX, OCD_OP_STX,
                OCD_OP_DEC, OCD_OP_INC, OCD_OP_TST, OCD_OP_CLR: begin
                    cc_d[`OCD_CC_N] = neg;
                    cc_d[`OCD_CC_Z] = zero;
                end
                OCD_OP_RTI: cc_d = alu.stacked_cc;
                OCD_OP_CLC: cc_d[`OCD_CC_C] = 1'b0;
                OCD_OP_SEC: cc_d[`OCD_CC_C] = 1'b1;
                OCD_OP_SEI, OCD_OP_SWT: cc_d[`OCD_CC_I] = 1'b1;
                OCD_OP_CLI, OCD_OP_STOP, OCD_OP_WAIT:
                    cc_d[`OCD_CC_I] = 1'b0;
                default: cc_d = cc_q;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cc_q <= `OCD_CC_RESET;
        end else begin
            cc_q <= cc_d;
        end
    end
endmodule
`default_nettype wire

// >>> verification/ocd_decoder_asserts.sv
// Concurrent checks on the opcode decoder ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module ocd_decoder_asserts
    import ocd_pkg::*;
(
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 reset,
    // Decode side
    input wire logic                 opcode_valid,
    input wire logic [7:0]           opcode,
    input wire ocd_pkg::ocd_decode_t decode_q,
    input wire logic                 decode_valid_q,
    input wire logic                 illegal_opcode_q,
    // Flag side
    input wire logic                 result_valid,
    input wire ocd_pkg::ocd_op_t     result_op,
    input wire ocd_pkg::ocd_alu_t    alu,
    input wire logic [4:0]           cc_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    valid_pulse_a: assert property (decode_valid_q == $past(opcode_valid))
        else $error("decode valid not one cycle after opcode");
    bit_index_a: assert property (opcode_valid |=>
        decode_q.bit_num == $past(opcode[3:1])) else $error("bit number wrong");
    illegal_flag_a: assert property (opcode_valid |=>
        illegal_opcode_q == (decode_q.op == OCD_OP_ILLEGAL))
        else $error("illegal indication disagrees with decode");
    word_offset_a: assert property (opcode_valid && opcode[7:4] == 4'hd |=>
        decode_q.offset_bytes == 2'd2) else $error("word offset count wrong");
    branch_sub_a: assert property (opcode_valid && opcode == 8'had |=>
        decode_q.op == OCD_OP_BSR) else $error("subroutine branch not decoded");
    half_keep_a: assert property (result_valid &&
        !(result_op inside {OCD_OP_ADD, OCD_OP_ADC, OCD_OP_RTI})
        |=> cc_q[4] == $past(cc_q[4])) else $error("half carry disturbed");
    stack_load_a: assert property (result_valid && result_op == OCD_OP_RTI
        |=> cc_q == $past(alu.stacked_cc)) else $error("stacked flags not loaded");
    sign_copy_a: assert property (result_valid &&
        result_op inside {OCD_OP_ADD, OCD_OP_SUB, OCD_OP_LDA, OCD_OP_TST}
        |=> cc_q[2] == $past(alu.result[7])) else $error("negative flag wrong");
    zero_flag_a: assert property (result_valid &&
        result_op inside {OCD_OP_ADD, OCD_OP_LDA, OCD_OP_CLR}
        |=> cc_q[1] == ($past(alu.result) == 8'h00)) else $error("zero flag wrong");
    mask_force_a: assert property (result_valid &&
        result_op inside {OCD_OP_SEI, OCD_OP_SWT} |=> cc_q[3])
        else $error("mask not set");
    mask_drop_a: assert property (result_valid &&
        result_op inside {OCD_OP_CLI, OCD_OP_STOP, OCD_OP_WAIT} |=> !cc_q[3])
        else $error("mask not cleared");
    flags_hold_a: assert property ((!result_valid || result_op inside
        {OCD_OP_BRANCH, OCD_OP_JMP, OCD_OP_JSR, OCD_OP_BSR}) |=> $stable(cc_q))
        else $error("flags changed without cause");

    cover property (result_valid && result_op == OCD_OP_RTI);
    cover property (illegal_opcode_q);
    cover property (opcode_valid ##1 opcode_valid);
endmodule
bind ocd_decoder ocd_decoder_asserts ocd_decoder_asserts_i (.clock, .reset,
    .opcode_valid, .opcode, .decode_q, .decode_valid_q, .illegal_opcode_q,
    .result_valid, .result_op, .alu, .cc_q);
`default_nettype wire

// >>> verification/ocd_decoder_bench.sv
// Self-checking bench: full opcode sweep, then flag updates and resets.
// Assumes the decoder, its package and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ocd_decoder_bench;
    import ocd_pkg::*;
    localparam ocd_op_t bad = OCD_OP_ILLEGAL;
    logic        clock, reset, opcode_valid, result_valid;
    logic        decode_valid_q, illegal_opcode_q;
    logic [7:0]  opcode;
    logic [4:0]  cc_q;
    ocd_op_t     result_op;
    ocd_alu_t    alu;
    ocd_decode_t decode_q, e;
    ocd_decode_t rows [256];
    int          miscompares, checked;
    ocd_op_t rmw [16] = '{OCD_OP_NEG, bad, bad, OCD_OP_COM, OCD_OP_LSR, bad,
        OCD_OP_ROR, OCD_OP_ASR, OCD_OP_LSL, OCD_OP_ROL, OCD_OP_DEC, bad,
        OCD_OP_INC, OCD_OP_TST, bad, OCD_OP_CLR};
    ocd_op_t ctl [32] = '{OCD_OP_RTI, OCD_OP_RTS, bad, OCD_OP_SWT, bad, bad,
        bad, bad, bad, bad, bad, bad, bad, bad, OCD_OP_STOP, OCD_OP_WAIT, bad,
        bad, bad, bad, bad, bad, bad, OCD_OP_TAX, OCD_OP_CLC, OCD_OP_SEC,
        OCD_OP_CLI, OCD_OP_SEI, OCD_OP_RSP, OCD_OP_NOP, bad, OCD_OP_TXA};
    ocd_mode_t hm [16] = '{OCD_MODE_BTB, OCD_MODE_BSC, OCD_MODE_RELATIVE,
        OCD_MODE_DIRECT, OCD_MODE_INHERENT, OCD_MODE_INHERENT, OCD_MODE_IX1,
        OCD_MODE_IX, OCD_MODE_INHERENT, OCD_MODE_INHERENT, OCD_MODE_IMMEDIATE,
        OCD_MODE_DIRECT, OCD_MODE_EXTENDED, OCD_MODE_IX2, OCD_MODE_IX1,
        OCD_MODE_IX};
    logic [1:0] hl [16] = '{2'd3, 2'd2, 2'd2, 2'd2, 2'd1, 2'd1, 2'd2, 2'd1,
        2'd1, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3, 2'd2, 2'd1};

    ocd_decoder ocd_decoder_i (.clock, .reset, .opcode_valid, .opcode,
        .decode_q, .decode_valid_q, .illegal_opcode_q, .result_valid,
        .result_op, .alu, .cc_q);

    function automatic ocd_decode_t expect_dec(logic [7:0] c);
        ocd_decode_t x;
        x = '0;
        x.mode = hm[c[7:4]];
        x.length = hl[c[7:4]];
        case (c[7:4])
            4'h0: x.op = c[0] ? OCD_OP_BRANCH_IF_BIT_CLEAR : OCD_OP_BRANCH_IF_BIT_SET;
            4'h1: x.op = c[0] ? OCD_OP_CLEAR_MEMORY_BIT : OCD_OP_SET_MEMORY_BIT;
            4'h2: x.op = OCD_OP_BRANCH;
            4'h8, 4'h9: x.op = ctl[c[4:0]];
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: x.op = rmw[c[3:0]];
            default: x.op = ocd_op_t'(OCD_OP_SUB + c[3:0]);
        endcase
        if (c == 8'had) begin
            x.op = OCD_OP_BSR;
            x.mode = OCD_MODE_RELATIVE;
        end
        if (c inside {8'ha7, 8'hac, 8'haf} || x.op == bad) begin
            x = '0;
            x.mode = OCD_MODE_NONE;
            x.length = 2'd1;
            x.illegal = 1'b1;
        end
        return x;
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic step(logic v, ocd_op_t op, logic [7:0] r, logic cy,
                        logic hc, logic [4:0] want);
        result_valid = v;
        result_op = op;
        alu = '{r, cy, hc, 5'h0a};
        @(negedge clock);
        check(cc_q, want);
    endtask

    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end

    initial begin
        {reset, opcode_valid, result_valid, opcode} = {3'b100, 8'h00};
        result_op = OCD_OP_NOP;
        alu = '0;
        repeat (8) @(negedge clock);
        check(cc_q, 5'h08);
        check(decode_valid_q, 1'b0);
        reset = 1'b0;
        for (int i = 0; i < 256; i++)
            rows[i] = expect_dec(8'(i));
        opcode_valid = 1'b1;
        for (int i = 0; i < 256; i++) begin
            opcode = 8'(i);
            e = rows[i];
            @(negedge clock);
            check({decode_q.op, decode_q.mode, decode_q.length, decode_q.illegal},
                  {e.op, e.mode, e.length, e.illegal});
            check({decode_valid_q, illegal_opcode_q}, {1'b1, e.illegal});
            if (i < 32)
                check(decode_q.bit_num, opcode[3:1]);
            if (i[7:4] == 4'h2)
                check(decode_q.cond, opcode[3:0]);
            if (e.mode inside {OCD_MODE_IX, OCD_MODE_IX1, OCD_MODE_IX2})
                check(decode_q.offset_bytes, e.length - 2'd1);
        end
        opcode_valid = 1'b0;
        step(1, OCD_OP_ADD, 8'h00, 1, 1, 5'h1b);
        step(1, OCD_OP_ADD, 8'h80, 0, 0, 5'h0c);
        step(0, OCD_OP_ADD, 8'h00, 1, 1, 5'h0c);
        step(1, OCD_OP_CLI, 8'h80, 1, 1, 5'h04);
        step(1, OCD_OP_SEC, 8'h80, 0, 1, 5'h05);
        step(1, OCD_OP_LDA, 8'h00, 0, 1, 5'h03);
        step(1, OCD_OP_ADC, 8'h0f, 0, 1, 5'h10);
        step(1, OCD_OP_SUB, 8'hff, 1, 0, 5'h15);
        step(1, OCD_OP_BRANCH, 8'h00, 0, 0, 5'h15);
        step(1, OCD_OP_JMP, 8'h00, 0, 0, 5'h15);
        step(1, OCD_OP_SWT, 8'h00, 0, 0, 5'h1d);
        step(1, OCD_OP_STOP, 8'h00, 0, 0, 5'h15);
        step(1, OCD_OP_SEI, 8'h00, 0, 0, 5'h1d);
        step(1, OCD_OP_WAIT, 8'h00, 0, 0, 5'h15);
        step(1, OCD_OP_CLC, 8'h00, 1, 0, 5'h14);
        step(1, OCD_OP_RTI, 8'h00, 0, 0, 5'h0a);
        step(1, OCD_OP_TST, 8'h80, 1, 1, 5'h0c);
        step(1, OCD_OP_CLR, 8'h00, 1, 1, 5'h0a);
        result_valid = 1'b0;
        reset = 1'b1;
        @(negedge clock);
        check({cc_q, decode_valid_q}, {5'h08, 1'b0});
        reset = 1'b0;
        opcode_valid = 1'b1;
        opcode = 8'had;
        @(negedge clock);
        opcode_valid = 1'b0;
        check(decode_q.op, OCD_OP_BSR);
        print_verdict();
    end
endmodule
`default_nettype wire
